// >>> hdl/rftx_device.sv
// radio transmitter control: serial config port, presets and tx sequencing
// Notes on behaviour
// - ctrl rising with data low starts a frame
// - each later ctrl rise moves one bit
// - first bit after entry selects read/write
// - host always writes all thirteen bits
// - read: 64 clocks, 13 config plus 43 test
// - transmitter sleeps while a frame runs
// - ctrl sampled after start delay, always driven
// - tx mode zero behaves as preset, register timer
// - defaults chosen by ctrl level before programming
// - next write only after transmit cycle ends
// - tx mode one forces continuous transmit
// - data activity in sleep starts a transmission
// - preset: high OOK 433.92, low FSK 868.3
// - bits 11:9 choose centre frequency
// - bit 8 FSK/OOK, bits 7:5 deviation
// - bit 4 selects 0 or 10 dBm
// - bit 3 selects 2 or 20 ms off timer
// - bits 2:0 offset carrier in pll steps
// - data rise wakes, hold, then data transmitted
// - preset sleep after 2 or 20 ms idle
module rftx_device
    import rftx_pkg::*;
#(
    parameter int START_CYC = rftx_pkg::POWERUP_SAMPLE_CYC,
    parameter int WAKE_CYC = rftx_pkg::WAKEUP_HOLD_CYC,
    parameter int OFF_SHORT_CYC = rftx_pkg::PA_OFF_SHORT_CYC,
    parameter int OFF_LONG_CYC = rftx_pkg::PA_OFF_LONG_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link
    rftx_link_if.dev lnk,
    // transmitter control
    output logic o_tx_on,
    output logic o_tx_data,
    output logic o_cfg_ready,
    output logic o_cfg_busy,
    output logic [rftx_pkg::CFG_W-1:0] o_cfg,
    // decoded settings
    output logic [19:0] o_center_khz,
    output logic [9:0] o_dev_100hz,
    output logic o_ook,
    output logic o_power_high,
    output logic signed [4:0] o_fine_steps
);
    import rftx_pkg::*;

    // ==========================================
    // link domain: serial shifter clocked by ctrl
    typedef enum logic [1:0] {L_IDLE, L_RW, L_WR, L_RD} rftx_lstate_t;
    rftx_lstate_t lst_q, lst_d;
    logic [EDGE_W-1:0] lcnt_q, lcnt_d;
    logic [SHIFT_W-1:0] sh_q, sh_d;
    logic [CFG_W-1:0] wr_word_q, wr_word_d;
    logic wr_tgl_q, wr_tgl_d;
    logic busy_q, busy_d;
    logic drv_n_q, drv_n_d;
    logic [CFG_W-1:0] cfg_q, cfg_d;
    logic link_rst;

    always_comb
    begin
        lst_d = lst_q;
        lcnt_d = lcnt_q;
        sh_d = sh_q;
        wr_word_d = wr_word_q;
        wr_tgl_d = wr_tgl_q;
        busy_d = busy_q;
        drv_n_d = 1'b1;
        case (lst_q)
            L_IDLE:
            begin
                if (!lnk.data)
                begin
                    // cfg_q is quiet here: it only moves after a frame
                    sh_d = {cfg_q, TEST_BITS};
                    lcnt_d = ENTRY_CNT;
                    busy_d = 1'b1;
                    lst_d = L_RW;
                end
            end
            L_RW:
            begin
                lcnt_d = FIRST_BIT_CNT;
                if (lnk.data == RW_READ)
                begin
                    lst_d = L_RD;
                    drv_n_d = 1'b0;
                end
                else
                begin
                    lst_d = L_WR;
                end
            end
            L_WR:
            begin
                sh_d = {sh_q[SHIFT_W-2:0], lnk.data};
                lcnt_d = lcnt_q + 1'b1;
                if (lcnt_q == WRITE_LAST)
                begin
                    wr_word_d = {sh_q[CFG_W-2:0], lnk.data};
                    wr_tgl_d = ~wr_tgl_q;
                    busy_d = 1'b0;
                    lst_d = L_IDLE;
                end
            end
            L_RD:
            begin
                if (lcnt_q == READ_LAST)
                begin
                    busy_d = 1'b0;
                    lst_d = L_IDLE;
                end
                else
                begin
                    sh_d = {sh_q[SHIFT_W-2:0], 1'b0};
                    lcnt_d = lcnt_q + 1'b1;
                    drv_n_d = 1'b0;
                end
            end
            default:
            begin
                lst_d = L_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // clock stops between frames; the last edge itself closes the frame
    always_ff @(posedge lnk.ctrl or posedge link_rst)
    begin
        if (link_rst)
        begin
            lst_q <= L_IDLE;
            lcnt_q <= '0;
            sh_q <= '0;
            wr_word_q <= CFG_RESET;
            wr_tgl_q <= 1'b0;
            busy_q <= 1'b0;
            drv_n_q <= 1'b1;
        end
        else
        begin
            lst_q <= lst_d;
            lcnt_q <= lcnt_d;
            sh_q <= sh_d;
            wr_word_q <= wr_word_d;
            wr_tgl_q <= wr_tgl_d;
            busy_q <= busy_d;
            drv_n_q <= drv_n_d;
        end
    end

    assign lnk.d_data_o = sh_q[SHIFT_W-1];
    assign lnk.d_data_oe_n = drv_n_q;

    // ==========================================
    // crossings into the reference domain
    logic ctrl_s;
    logic data_s;
    logic busy_s;
    logic tgl_s;

    rftx_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({lnk.ctrl, lnk.data, busy_q, wr_tgl_q}),
        .o_sync({ctrl_s, data_s, busy_s, tgl_s})
    );

    // ==========================================
    // power-up sampling and configuration register
    logic [TIMER_W-1:0] st_q, st_d;
    logic ready_q, ready_d;
    logic preset_q, preset_d;
    logic tgl_seen_q, tgl_seen_d;

    // link side held until power-up sampling ends, so a ctrl level set
    // before then is no entry; ctrl stands still when this lets go
    assign link_rst = i_sys_rst || !ready_q;

    always_comb
    begin
        st_d = st_q;
        ready_d = ready_q;
        preset_d = preset_q;
        cfg_d = cfg_q;
        tgl_seen_d = tgl_s;
        if (!ready_q)
        begin
            st_d = st_q + 1'b1;
            if (st_q == TIMER_W'(START_CYC - 1))
            begin
                ready_d = 1'b1;
                preset_d = ctrl_s;
                cfg_d = ctrl_s ? CFG_DEF_HIGH : CFG_DEF_LOW;
            end
        end
        else if (tgl_s != tgl_seen_q)
        begin
            // word held steady since its toggle left the link domain
            cfg_d = wr_word_q;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= '0;
            ready_q <= 1'b0;
            preset_q <= 1'b0;
            cfg_q <= CFG_RESET;
            tgl_seen_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ready_q <= ready_d;
            preset_q <= preset_d;
            cfg_q <= cfg_d;
            tgl_seen_q <= tgl_seen_d;
        end
    end

    // ==========================================
    // transmitter sequencing
    typedef enum logic [1:0] {T_SLEEP, T_WAKE, T_ON} rftx_tstate_t;
    rftx_tstate_t tst_q, tst_d;
    logic [TIMER_W-1:0] tm_q, tm_d;
    logic data_prev_q;
    logic tx_on_q, tx_on_d;
    logic tx_data_q, tx_data_d;
    logic forced;
    logic [TIMER_W-1:0] off_lim;

    assign forced = cfg_q[TXMODE_BIT];
    assign off_lim = cfg_q[TOFF_BIT] ? TIMER_W'(OFF_LONG_CYC - 1)
                                     : TIMER_W'(OFF_SHORT_CYC - 1);

    always_comb
    begin
        tst_d = tst_q;
        tm_d = tm_q;
        case (tst_q)
            T_SLEEP:
            begin
                tm_d = '0;
                // wait for a written word still crossing, else the old
                // mode bit would start a transmission
                if (ready_q && !busy_s && (tgl_s == tgl_seen_q))
                begin
                    if (forced)
                        tst_d = T_ON;
                    else if (data_s && !data_prev_q)
                        tst_d = T_WAKE;
                end
            end
            T_WAKE:
            begin
                tm_d = tm_q + 1'b1;
                if (busy_s)
                    tst_d = T_SLEEP;
                else if (tm_q == TIMER_W'(WAKE_CYC - 1))
                begin
                    tst_d = T_ON;
                    tm_d = '0;
                end
            end
            T_ON:
            begin
                if (busy_s)
                    tst_d = T_SLEEP;
                else if (forced)
                    tm_d = '0;
                else if (data_s != data_prev_q)
                    tm_d = '0;
                else if (tm_q == off_lim)
                    tst_d = T_SLEEP;
                else
                    tm_d = tm_q + 1'b1;
            end
            default:
            begin
                tst_d = T_SLEEP;
                tm_d = '0;
            end
        endcase
        tx_on_d = (tst_d == T_ON);
        tx_data_d = tx_on_d && data_s;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tst_q <= T_SLEEP;
            tm_q <= '0;
            data_prev_q <= 1'b0;
            tx_on_q <= 1'b0;
            tx_data_q <= 1'b0;
        end
        else
        begin
            tst_q <= tst_d;
            tm_q <= tm_d;
            data_prev_q <= data_s;
            tx_on_q <= tx_on_d;
            tx_data_q <= tx_data_d;
        end
    end

    // ==========================================
    // outputs
    assign o_tx_on = tx_on_q;
    assign o_tx_data = tx_data_q;
    assign o_cfg_ready = ready_q;
    assign o_cfg_busy = busy_s;
    assign o_cfg = cfg_q;
    assign o_center_khz = center_khz(cfg_q[FREQ_HI:FREQ_LO]);
    // deviation means nothing under OOK, so it reads zero there
    assign o_dev_100hz = cfg_q[MOD_BIT] ? 10'h000
                         : dev_100hz(cfg_q[DEV_HI:DEV_LO]);
    assign o_ook = cfg_q[MOD_BIT];
    assign o_power_high = cfg_q[PWR_BIT];
    assign o_fine_steps = fine_steps(cfg_q[FINE_HI:FINE_LO]);
endmodule

// >>> hdl/rftx_pkg.sv
// shared constants, field layout and decode functions for the radio control
package rftx_pkg;
    // ==========================================
    // configuration word layout
    localparam int CFG_W = 13;
    localparam int TEST_W = 43;
    localparam int SHIFT_W = CFG_W + TEST_W;
    localparam int TXMODE_BIT = 12;
    localparam int FREQ_HI = 11;
    localparam int FREQ_LO = 9;
    localparam int MOD_BIT = 8;
    localparam int DEV_HI = 7;
    localparam int DEV_LO = 5;
    localparam int PWR_BIT = 4;
    localparam int TOFF_BIT = 3;
    localparam int FINE_HI = 2;
    localparam int FINE_LO = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h0000;
    localparam logic [CFG_W-1:0] CFG_DEF_LOW = 13'h0850;
    localparam logic [CFG_W-1:0] CFG_DEF_HIGH = 13'h0558;
    // test bits shifted out after the configuration; value arbitrary
    localparam logic [TEST_W-1:0] TEST_BITS = 43'h000_0000_0000;

    // ==========================================
    // serial frame
    localparam logic RW_READ = 1'b1;
    localparam logic [5:0] ENTRY_CNT = 6'h01;
    localparam logic [5:0] FIRST_BIT_CNT = 6'h02;
    localparam logic [5:0] WRITE_LAST = 6'h0e;
    localparam logic [5:0] READ_LAST = 6'h3f;
    localparam int EDGE_W = 6;

    // ==========================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int POWERUP_SAMPLE_US = 1000;
    localparam int WAKEUP_HOLD_US = 100;
    localparam int PA_OFF_SHORT_US = 2000;
    localparam int PA_OFF_LONG_US = 20000;
    localparam int POWERUP_SAMPLE_CYC = POWERUP_SAMPLE_US * CLK_MHZ;
    localparam int WAKEUP_HOLD_CYC = WAKEUP_HOLD_US * CLK_MHZ;
    localparam int PA_OFF_SHORT_CYC = PA_OFF_SHORT_US * CLK_MHZ;
    localparam int PA_OFF_LONG_CYC = PA_OFF_LONG_US * CLK_MHZ;
    localparam int TIMER_W = 24;
    localparam int HALF_CYC = 4;

    // ==========================================
    // field decoders
    function automatic logic [19:0] center_khz(input logic [2:0] code);
        case (code)
            3'h0: center_khz = 20'd418000;
            3'h1: center_khz = 20'd433420;
            3'h2: center_khz = 20'd433920;
            3'h3: center_khz = 20'd864000;
            3'h4: center_khz = 20'd868300;
            3'h5: center_khz = 20'd868650;
            3'h6: center_khz = 20'd868950;
            default: center_khz = 20'd869850;
        endcase
    endfunction

    // deviation in units of 100 Hz
    function automatic logic [9:0] dev_100hz(input logic [2:0] code);
        case (code)
            3'h0: dev_100hz = 10'd100;
            3'h1: dev_100hz = 10'd125;
            3'h2: dev_100hz = 10'd200;
            3'h3: dev_100hz = 10'd250;
            3'h4: dev_100hz = 10'd400;
            3'h5: dev_100hz = 10'd500;
            3'h6: dev_100hz = 10'd800;
            default: dev_100hz = 10'd1000;
        endcase
    endfunction

    // offset in pll steps, two's complement
    function automatic logic signed [4:0] fine_steps(input logic [2:0] code);
        case (code)
            3'h3: fine_steps = 5'sd6;
            3'h2: fine_steps = 5'sd4;
            3'h1: fine_steps = 5'sd2;
            3'h0: fine_steps = 5'sd0;
            3'h7: fine_steps = -5'sd2;
            3'h6: fine_steps = -5'sd4;
            3'h5: fine_steps = -5'sd6;
            default: fine_steps = -5'sd8;
        endcase
    endfunction
endpackage

// >>> hdl/rftx_link_if.sv
// two-wire link between the host core and the radio transmitter
interface rftx_link_if;
    logic ctrl;
    logic h_data_o;
    logic h_data_oe_n;
    logic d_data_o;
    logic d_data_oe_n;
    logic data;

    // weak pull-down when nobody drives
    assign data = !h_data_oe_n ? h_data_o :
                  (!d_data_oe_n ? d_data_o : 1'b0);

    modport host (
        output ctrl,
        output h_data_o,
        output h_data_oe_n,
        input data
    );

    modport dev (
        input ctrl,
        input data,
        output d_data_o,
        output d_data_oe_n
    );
endinterface

// >>> hdl/rftx_sync.sv
// two-flop synchroniser for levels and toggles
module rftx_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// >>> hdl/rftx_host.sv
// host end: drives ctrl as a divided clock and runs config frames
module rftx_host
    import rftx_pkg::*;
#(
    parameter int HALF = rftx_pkg::HALF_CYC,
    parameter int GAP_CYC = rftx_pkg::PA_OFF_LONG_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link
    rftx_link_if.host lnk,
    // user requests
    input wire logic i_start,
    input wire logic i_read,
    input wire logic [rftx_pkg::CFG_W-1:0] i_wr_word,
    input wire logic i_preset_high,
    input wire logic i_tx_data,
    output logic o_ready,
    // read answer
    output logic [rftx_pkg::CFG_W-1:0] o_rd_word,
    output logic o_rd_valid
);
    import rftx_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP}
        rftx_hstate_t;
    rftx_hstate_t st_q, st_d;
    logic [7:0] ph_q, ph_d;
    logic [EDGE_W-1:0] edge_q, edge_d;
    logic [CFG_W+1:0] tx_q, tx_d;
    logic [CFG_W-1:0] rx_q, rx_d;
    logic [TIMER_W-1:0] gap_q, gap_d;
    logic rd_q, rd_d;
    logic ctrl_q, ctrl_d;
    logic dat_q, dat_d;
    logic oe_n_q, oe_n_d;
    logic [CFG_W-1:0] rd_word_q, rd_word_d;
    logic rd_valid_q, rd_valid_d;
    logic data_s;
    logic ph_done;
    logic [EDGE_W-1:0] last_edge;

    // device drives the data pin off our own ctrl, yet it is still a pin
    rftx_sync #(
        .WIDTH(1)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(lnk.data),
        .o_sync(data_s)
    );

    assign ph_done = (ph_q == 8'(HALF - 1));
    assign last_edge = rd_q ? READ_LAST : WRITE_LAST;

    always_comb
    begin
        st_d = st_q;
        ph_d = ph_done ? 8'h00 : ph_q + 8'h01;
        edge_d = edge_q;
        tx_d = tx_q;
        rx_d = rx_q;
        gap_d = gap_q;
        rd_d = rd_q;
        ctrl_d = ctrl_q;
        dat_d = dat_q;
        oe_n_d = oe_n_q;
        rd_word_d = rd_word_q;
        rd_valid_d = 1'b0;
        case (st_q)
            H_IDLE:
            begin
                ph_d = 8'h00;
                ctrl_d = i_preset_high;
                dat_d = i_tx_data;
                oe_n_d = 1'b0;
                if (i_start)
                begin
                    tx_d = {1'b0, i_read, i_wr_word};
                    rd_d = i_read;
                    edge_d = '0;
                    ctrl_d = 1'b0;
                    dat_d = 1'b0;
                    st_d = H_SETUP;
                end
            end
            H_SETUP:
            begin
                if (ph_done)
                    st_d = H_LOW;
            end
            H_LOW:
            begin
                if (ph_done)
                begin
                    ctrl_d = 1'b1;
                    st_d = H_HIGH;
                    if (rd_q && edge_q >= FIRST_BIT_CNT &&
                        edge_q <= WRITE_LAST)
                        rx_d = {rx_q[CFG_W-2:0], data_s};
                end
            end
            H_HIGH:
            begin
                if (ph_done)
                begin
                    ctrl_d = 1'b0;
                    if (edge_q == last_edge)
                    begin
                        st_d = H_GAP;
                        gap_d = '0;
                        dat_d = 1'b0;
                        oe_n_d = 1'b0;
                        rd_valid_d = rd_q;
                        if (rd_q)
                            rd_word_d = rx_q;
                    end
                    else
                    begin
                        edge_d = edge_q + 1'b1;
                        tx_d = {tx_q[CFG_W:0], 1'b0};
                        dat_d = tx_q[CFG_W];
                        // release the pin once the device starts answering
                        oe_n_d = rd_q && (edge_q >= ENTRY_CNT);
                        st_d = H_LOW;
                    end
                end
            end
            H_GAP:
            begin
                gap_d = gap_q + 1'b1;
                // lasts the long amplifier off time, PA_OFF_LONG_CYC by default
                if (gap_q == TIMER_W'(GAP_CYC - 1))
                    st_d = H_IDLE;
            end
            default:
            begin
                st_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= H_IDLE;
            ph_q <= '0;
            edge_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            gap_q <= '0;
            rd_q <= 1'b0;
            ctrl_q <= 1'b0;
            dat_q <= 1'b0;
            oe_n_q <= 1'b0;
            rd_word_q <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ph_q <= ph_d;
            edge_q <= edge_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            gap_q <= gap_d;
            rd_q <= rd_d;
            ctrl_q <= ctrl_d;
            dat_q <= dat_d;
            oe_n_q <= oe_n_d;
            rd_word_q <= rd_word_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign lnk.ctrl = ctrl_q;
    assign lnk.h_data_o = dat_q;
    assign lnk.h_data_oe_n = oe_n_q;
    assign o_ready = (st_q == H_IDLE);
    assign o_rd_word = rd_word_q;
    assign o_rd_valid = rd_valid_q;
endmodule

// >>> verification/rftx_link_monitor.sv
// assertions on the two-wire link and the transmitter state
module rftx_link_monitor (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link
    input wire logic ctrl,
    input wire logic h_data_o,
    input wire logic h_data_oe_n,
    input wire logic data,
    // transmitter state
    input wire logic o_tx_on,
    input wire logic o_tx_data,
    input wire logic o_cfg_busy,
    input wire logic [12:0] o_cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ==========================================
    // ctrl rises counted while the host has let go of data
    logic ctrl_q;
    logic ctrl_d;
    logic [6:0] rise_cnt_q;
    logic [6:0] rise_cnt_d;

    always_comb
    begin
        ctrl_d = ctrl;
        rise_cnt_d = rise_cnt_q;
        if (!h_data_oe_n)
            rise_cnt_d = 7'h00;
        else if (ctrl && !ctrl_q)
            rise_cnt_d = rise_cnt_q + 7'h01;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ctrl_q <= 1'b0;
            rise_cnt_q <= 7'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rise_cnt_q <= rise_cnt_d;
        end
    end

    // ==========================================
    // properties
    a_ctrl_high_half: assert property ($rose(ctrl) |-> ctrl [*4])
        else $error("ctrl high phase too short");
    a_host_data_hold: assert property ($rose(ctrl) |->
        $stable(h_data_o) && $stable(h_data_oe_n))
        else $error("host data moved at ctrl rise");
    // edge0 and edge1 precede the release, so 62 of 64 edges remain
    a_read_len: assert property ($fell(h_data_oe_n) |->
        rise_cnt_q == 7'h3e)
        else $error("read frame edge count wrong");
    a_sleep_in_frame: assert property (o_cfg_busy [*3] |-> !o_tx_on)
        else $error("transmitter on during frame");
    a_forced_tx_on: assert property ($rose(o_cfg[12]) |->
        ##[0:8] o_tx_on)
        else $error("forced transmit did not start");
    a_forced_drop: assert property (o_cfg[12] && $fell(o_tx_on) |->
        ##[0:4] o_cfg_busy)
        else $error("forced transmit dropped without a frame");
    a_wake_delay: assert property ($rose(o_tx_on) && !o_cfg[12] |->
        $past(data, 8))
        else $error("transmitter woke before hold time");
    a_tx_data_gate: assert property (o_tx_data ==
        (o_tx_on && $past(data, 3)))
        else $error("tx data passed while asleep");
endmodule

// >>> verification/tb.sv
// self-checking bench: host and device ends joined by the link
`define CHK(got, exp) \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
        bad_count++; \
        $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_read = 1'b0;
    logic [12:0] i_wr_word = 13'h0000;
    logic i_preset_high = 1'b0;
    logic i_tx_data = 1'b0;
    logic o_ready, o_rd_valid, o_tx_on, o_tx_data, o_cfg_ready, o_cfg_busy;
    logic o_ook, o_power_high;
    logic [12:0] o_rd_word, o_cfg;
    logic [19:0] o_center_khz;
    logic [9:0] o_dev_100hz;
    logic signed [4:0] o_fine_steps;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int busy_run = 0;
    logic seen_busy_tx = 1'b0;

    // ==========================================
    // expected decodes, one row per field code
    localparam logic [19:0] KHZ [8] = '{20'h660d0, 20'h69d0c, 20'h69f00,
        20'hd2f00, 20'hd3fcc, 20'hd412a, 20'hd4256, 20'hd45da};
    localparam logic [9:0] DEV [8] = '{10'h064, 10'h07d, 10'h0c8, 10'h0fa,
        10'h190, 10'h1f4, 10'h320, 10'h3e8};
    localparam logic [4:0] FINE [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
        5'h18, 5'h1a, 5'h1c, 5'h1e};

    // ==========================================
    // ends, link and checker
    rftx_link_if lnk ();
    // short counts keep the run brief
    rftx_device #(.START_CYC(20), .WAKE_CYC(10), .OFF_SHORT_CYC(30),
        .OFF_LONG_CYC(60)) i_rftx_device (.i_ref_clk, .i_sys_rst, .lnk,
        .o_tx_on, .o_tx_data, .o_cfg_ready, .o_cfg_busy, .o_cfg,
        .o_center_khz, .o_dev_100hz, .o_ook, .o_power_high, .o_fine_steps);
    rftx_host #(.GAP_CYC(100)) i_rftx_host (.i_ref_clk,
        .i_sys_rst, .lnk, .i_start, .i_read, .i_wr_word, .i_preset_high,
        .i_tx_data, .o_ready, .o_rd_word, .o_rd_valid);
    rftx_link_monitor i_rftx_link_monitor (.i_ref_clk, .i_sys_rst,
        .ctrl(lnk.ctrl), .h_data_o(lnk.h_data_o),
        .h_data_oe_n(lnk.h_data_oe_n), .data(lnk.data), .o_tx_on,
        .o_tx_data, .o_cfg_busy, .o_cfg);

    always #2 i_ref_clk = ~i_ref_clk;

    // sampled on the falling edge, away from register updates
    always @(negedge i_ref_clk)
    begin
        cyc++;
        busy_run = (o_cfg_busy === 1'b1) ? busy_run + 1 : 0;
        if (busy_run >= 3 && o_tx_on !== 1'b0)
            seen_busy_tx = 1'b1;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic frame(input logic rd, input logic [12:0] w);
        while (o_ready !== 1'b1)
            tick(1);
        i_start = 1'b1;
        i_read = rd;
        i_wr_word = w;
        tick(1);
        i_start = 1'b0;
        while (o_ready !== 1'b1)
            tick(1);
    endtask

    task automatic do_reset(input logic hi);
        i_preset_high = hi;
        i_sys_rst = 1'b1;
        tick(8);
        i_sys_rst = 1'b0;
        tick(15);
        `CHK(o_cfg_ready, 1'b0)
        while (o_cfg_ready !== 1'b1)
            tick(1);
    endtask

    initial
    begin
        logic [12:0] w;
        do_reset(1'b0);
        `CHK(o_cfg, 13'h0850)
        `CHK(o_center_khz, KHZ[4])
        `CHK(o_dev_100hz, DEV[2])
        do_reset(1'b1);
        `CHK(o_cfg, 13'h0558)
        `CHK(o_center_khz, KHZ[2])
        `CHK(o_ook, 1'b1)
        `CHK(o_power_high, 1'b1)
        `CHK(o_cfg_busy, 1'b0)
        // a high idle ctrl would turn every frame's end into a new entry
        i_preset_high = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            w = {1'b0, 3'(i), i == 7, 3'(i), i[1], 1'b0, 3'(i)};
            frame(1'b0, w);
            `CHK(o_cfg, w)
            `CHK(o_center_khz, KHZ[i])
            `CHK(o_dev_100hz, i == 7 ? 10'h000 : DEV[i])
            `CHK(o_ook, i == 7)
            `CHK(o_power_high, i[1])
            `CHK(o_fine_steps, FINE[i])
            frame(1'b1, 13'h0000);
            `CHK(o_rd_word, w)
        end
        // forced transmit must outlast the idle timer
        frame(1'b0, 13'h1000);
        tick(200);
        `CHK(o_tx_on, 1'b1)
        frame(1'b0, 13'h0000);
        `CHK(o_tx_on, 1'b0)
        `CHK(seen_busy_tx, 1'b0)
        for (int t = 0; t < 2; t++)
        begin
            frame(1'b0, {9'h000, t[0], 3'h0});
            i_tx_data = 1'b1;
            tick(5);
            `CHK(o_tx_on, 1'b0)
            tick(25);
            `CHK(o_tx_on, 1'b1)
            `CHK(o_tx_data, 1'b1)
            i_tx_data = 1'b0;
            tick(6);
            `CHK(o_tx_data, 1'b0)
            tick(t ? 45 : 15);
            `CHK(o_tx_on, 1'b1)
            tick(25);
            `CHK(o_tx_on, 1'b0)
        end
        close_out();
    end
endmodule
